/* File: verilog/ir_remote_pkg.sv */
package ir_remote_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [15:0] CLOCK_CONTROL_IDX = 16'h0720;
   localparam logic [15:0] COUNTER_CONTROL_IDX = 16'h0722;
   localparam logic [15:0] DATA_COUNTER_VALUE_IDX = 16'h0724;
   localparam logic [15:0] ACTIVE_LENGTH_IDX = 16'h0726;
   localparam logic [15:0] CYCLE_LENGTH_IDX = 16'h0728;
   localparam logic [15:0] STATUS_FLAGS_IDX = 16'h072A;
   localparam logic [15:0] INTERRUPT_MASK_IDX = 16'h072C;
   localparam int ADDR_W = 16;
   localparam int IDX_LSB = 2;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SOURCE_SELECT_BIT = 0;
   localparam int DIVIDER_SELECT_LSB = 4;
   localparam int DIVIDER_SELECT_MSB = 7;
   localparam int BLOCK_ENABLE_BIT = 0;
   localparam int SOFT_RESET_BIT = 1;
   localparam int ONE_SHOT_SELECT_BIT = 2;
   localparam int COMPARE_BUFFER_ENABLE_BIT = 3;
   localparam int OUTPUT_INVERT_BIT = 4;
   localparam int COUNTER_RUN_BIT = 8;
   localparam int COUNTER_PRESET_BIT = 9;
   localparam int ACTIVE_COMPARE_FLAG_BIT = 0;
   localparam int CYCLE_COMPARE_FLAG_BIT = 1;
   localparam int COUNTER_RUNNING_FLAG_BIT = 10;

   // ----------------------------------------------------------------
   // widths, reset values, divider limits
   // ----------------------------------------------------------------
   localparam int REG_W = 16;
   localparam int DIV_W = 4;
   localparam int PRESCALE_W = 15;
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
   localparam logic [REG_W-1:0] CLOCK_CONTROL_WMASK = 16'h00F1; // writable clocking bits
   localparam logic [DIV_W-1:0] SLOW_MAX_CODE = 4'h8;
   localparam logic [DIV_W-1:0] CODE_UNDIVIDED = 4'h0;

endpackage

/* File: verilog/ir_tick_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module ir_tick_divider
(
   input  wire logic                                   clk,
   input  wire logic                                   rst_n,
   input  wire logic                                   clk_en,
   input  wire logic                                   clear,
   input  wire logic                                   fast_osc,
   input  wire logic                                   slow_osc,
   input  wire logic                                   slow_source,
   input  wire logic [ir_remote_pkg::DIV_W-1:0]        code,
   output logic                                        step
);

   logic [ir_remote_pkg::PRESCALE_W-1:0] prescale_reg;
   logic [ir_remote_pkg::DIV_W-1:0]      eff_code;
   logic [ir_remote_pkg::PRESCALE_W-1:0] mask;
   logic [2:0]                           fast_sync_reg;
   logic [2:0]                           slow_sync_reg;
   logic                                 src_tick;

   // ----------------------------------------------------------------
   // oscillator inputs
   // ----------------------------------------------------------------
   // two-stage synchronisers, third stage only for edge detection;
   // frozen while disabled, so software soft-resets after re-enabling
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         fast_sync_reg <= '0;
         slow_sync_reg <= '0;
      end
      else if (clk_en)
      begin
         fast_sync_reg <= {fast_sync_reg[1:0], fast_osc};
         slow_sync_reg <= {slow_sync_reg[1:0], slow_osc};
      end
   end

   // source edge; source must run below half the core rate
   assign src_tick = slow_source ? (slow_sync_reg[1] && !slow_sync_reg[2])
                                 : (fast_sync_reg[1] && !fast_sync_reg[2]);

   // ----------------------------------------------------------------
   // ratio select
   // ----------------------------------------------------------------
   // slow source above its top code runs undivided
   always_comb
   begin
      if (slow_source && (code > ir_remote_pkg::SLOW_MAX_CODE))
      begin
         eff_code = ir_remote_pkg::CODE_UNDIVIDED;
      end
      else
      begin
         eff_code = code;
      end
      mask = ~({ir_remote_pkg::PRESCALE_W{1'b1}} << eff_code);
   end

   // prescaler counts source ticks; step fires every 2^eff_code ticks
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prescale_reg <= '0;
         step <= 1'b0;
      end
      else if (clk_en)
      begin
         if (clear)
         begin
            prescale_reg <= '0;
            step <= 1'b0;
         end
         else if (src_tick)
         begin
            step <= ((prescale_reg & mask) == mask);
            prescale_reg <= (prescale_reg & mask) == mask ? '0 : prescale_reg + 1'b1;
         end
         else
         begin
            step <= 1'b0;
         end
      end
   end

endmodule // ir_tick_divider
`default_nettype wire

/* File: verilog/ir_remote_data_signal_generator.sv */
// What this block does
// - fast source divides by two to code
// - source bit picks oscillator; slow codes above 8 run undivided
// - one-shot stops after cycle, else repeats
// - soft reset clears counters, flags, self-clears
// - enable bit gates all counting
// - output active when running and counter is zero
// - output inactive past active length
// - invert bit selects active level
// - cycle ends on the step taken at cycle length
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ir_remote_data_signal_generator
(
   input  wire logic                                   CORE_CLK,
   input  wire logic                                   RST_N,
   input  wire logic                                   CLK_EN,
   input  wire logic                                   PSEL,
   input  wire logic                                   PENABLE,
   input  wire logic                                   PWRITE,
   input  wire logic [ir_remote_pkg::ADDR_W-1:0]       PADDR,
   input  wire logic [31:0]                            PWDATA,
   input  wire logic [3:0]                             PSTRB,
   output logic      [31:0]                            PRDATA,
   output logic                                        PREADY,
   output logic                                        PSLVERR,
   input  wire logic                                   FAST_INTERNAL_OSCILLATOR,
   input  wire logic                                   LOW_SPEED_OSCILLATOR,
   output logic                                        IR_OUTPUT_PIN,
   output logic                                        IRQ
);

   localparam int W = ir_remote_pkg::REG_W;

   logic [W-1:0]  clock_control_reg;
   logic          block_enable_reg, soft_reset_reg, one_shot_select_reg;
   logic          compare_buffer_enable_reg, output_invert_reg;
   logic          counter_run_reg, counter_preset_reg;
   logic [W-1:0]  data_counter_reg, active_length_reg, cycle_length_reg;
   logic [1:0]    flags_reg, mask_reg;
   logic [15:0]   idx;
   logic          access, wr, mapped;
   logic [W-1:0]  wdata, read_word;
   logic          step, count_step, cycle_end, active_end, out_active, counter_clear;
   default clocking core_cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N); // checks pause while in reset

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // byte-lane merge so software may write low byte then high byte
   function automatic logic [W-1:0] merge(input logic [W-1:0] old_val,
                                          input logic [W-1:0] new_val,
                                          input logic [1:0]   lanes);
      merge = {lanes[1] ? new_val[15:8] : old_val[15:8],
               lanes[0] ? new_val[7:0] : old_val[7:0]};
   endfunction

   // write of a single control bit on lane 0 or 1
   function automatic logic bit_written(input logic [W-1:0] data,
                                        input logic [1:0]   lanes,
                                        input int           pos);
      bit_written = lanes[pos / 8] && data[pos];
   endfunction

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign idx = PADDR >> ir_remote_pkg::IDX_LSB;
   assign access = PSEL && PENABLE;
   assign wr = access && PWRITE && PREADY;
   assign wdata = PWDATA[W-1:0];

   // read mux; unused and reserved bits return zero
   always_comb
   begin
      read_word = '0;
      mapped = 1'b1;
      case (idx)
         ir_remote_pkg::CLOCK_CONTROL_IDX:
            read_word = clock_control_reg;
         ir_remote_pkg::COUNTER_CONTROL_IDX:
         begin
            read_word[ir_remote_pkg::BLOCK_ENABLE_BIT] = block_enable_reg;
            read_word[ir_remote_pkg::SOFT_RESET_BIT] = soft_reset_reg;
            read_word[ir_remote_pkg::ONE_SHOT_SELECT_BIT] = one_shot_select_reg;
            read_word[ir_remote_pkg::COMPARE_BUFFER_ENABLE_BIT] = compare_buffer_enable_reg;
            read_word[ir_remote_pkg::OUTPUT_INVERT_BIT] = output_invert_reg;
            read_word[ir_remote_pkg::COUNTER_RUN_BIT] = counter_run_reg;
            read_word[ir_remote_pkg::COUNTER_PRESET_BIT] = counter_preset_reg;
         end
         ir_remote_pkg::DATA_COUNTER_VALUE_IDX:
            read_word = data_counter_reg;
         ir_remote_pkg::ACTIVE_LENGTH_IDX:
            read_word = active_length_reg;
         ir_remote_pkg::CYCLE_LENGTH_IDX:
            read_word = cycle_length_reg;
         ir_remote_pkg::STATUS_FLAGS_IDX:
         begin
            read_word[ir_remote_pkg::CYCLE_COMPARE_FLAG_BIT] = flags_reg[1];
            read_word[ir_remote_pkg::ACTIVE_COMPARE_FLAG_BIT] = flags_reg[0];
            read_word[ir_remote_pkg::COUNTER_RUNNING_FLAG_BIT] = counter_run_reg;
         end
         ir_remote_pkg::INTERRUPT_MASK_IDX:
            read_word[1:0] = mask_reg;
         default:
            mapped = 1'b0;
      endcase
   end

   // one wait state: ready rises the cycle after the access phase opens
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end
      else if (CLK_EN)
      begin
         PREADY <= access && !PREADY;
         PRDATA <= {16'h0000, read_word};
         PSLVERR <= access && !PREADY && !mapped;
      end
   end

   // ----------------------------------------------------------------
   // divided count tick
   // ----------------------------------------------------------------
   // prescaler restarts when counting is held or cleared while the block is enabled
   assign counter_clear = soft_reset_reg || counter_preset_reg || !counter_run_reg;

   ir_tick_divider u_divider
   (
      .clk         (CORE_CLK),
      .rst_n       (RST_N),
      .clk_en      (CLK_EN && block_enable_reg),
      .clear       (counter_clear),
      .fast_osc    (FAST_INTERNAL_OSCILLATOR),
      .slow_osc    (LOW_SPEED_OSCILLATOR),
      .slow_source (clock_control_reg[ir_remote_pkg::SOURCE_SELECT_BIT]),
      .code        (clock_control_reg[ir_remote_pkg::DIVIDER_SELECT_MSB:
                                      ir_remote_pkg::DIVIDER_SELECT_LSB]),
      .step        (step)
   );

   // operating clock only reaches the counter while enabled
   assign count_step = step && block_enable_reg && counter_run_reg
                    && !soft_reset_reg && !counter_preset_reg;
   assign cycle_end = count_step && (data_counter_reg == cycle_length_reg);
   assign active_end = count_step && (data_counter_reg == active_length_reg);
   assign out_active = counter_run_reg && (data_counter_reg <= active_length_reg);

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // clocking is not locked by hardware; software keeps it still while running
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         clock_control_reg <= ir_remote_pkg::REG_RESET;
         active_length_reg <= ir_remote_pkg::REG_RESET;
         cycle_length_reg <= ir_remote_pkg::REG_RESET;
         mask_reg <= '0;
      end
      else if (CLK_EN && wr)
      begin
         case (idx)
            ir_remote_pkg::CLOCK_CONTROL_IDX:
               clock_control_reg <= merge(clock_control_reg, wdata, PSTRB[1:0])
                                  & ir_remote_pkg::CLOCK_CONTROL_WMASK;
            ir_remote_pkg::ACTIVE_LENGTH_IDX:
               active_length_reg <= merge(active_length_reg, wdata, PSTRB[1:0]);
            ir_remote_pkg::CYCLE_LENGTH_IDX:
               cycle_length_reg <= merge(cycle_length_reg, wdata, PSTRB[1:0]);
            ir_remote_pkg::INTERRUPT_MASK_IDX:
               if (PSTRB[0])
                  mask_reg <= wdata[1:0];
            default:
               mask_reg <= mask_reg;
         endcase
      end
   end

   // mode bits of the counter control word
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         block_enable_reg <= 1'b0;
         one_shot_select_reg <= 1'b0;
         compare_buffer_enable_reg <= 1'b0;
         output_invert_reg <= 1'b0;
      end
      else if (CLK_EN && wr && (idx == ir_remote_pkg::COUNTER_CONTROL_IDX) && PSTRB[0])
      begin
         block_enable_reg <= wdata[ir_remote_pkg::BLOCK_ENABLE_BIT];
         one_shot_select_reg <= wdata[ir_remote_pkg::ONE_SHOT_SELECT_BIT];
         compare_buffer_enable_reg <= wdata[ir_remote_pkg::COMPARE_BUFFER_ENABLE_BIT];
         output_invert_reg <= wdata[ir_remote_pkg::OUTPUT_INVERT_BIT];
      end
   end

   // ----------------------------------------------------------------
   // soft reset, preset, run
   // ----------------------------------------------------------------
   // soft reset and preset self-clear after one cycle; run holds until written, soft reset or one-shot end
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         soft_reset_reg <= 1'b0;
         counter_preset_reg <= 1'b0;
         counter_run_reg <= 1'b0;
      end
      else if (CLK_EN)
      begin
         soft_reset_reg <= wr && (idx == ir_remote_pkg::COUNTER_CONTROL_IDX)
            && bit_written(wdata, PSTRB[1:0], ir_remote_pkg::SOFT_RESET_BIT);
         if (soft_reset_reg)
         begin
            counter_preset_reg <= 1'b0;
            counter_run_reg <= 1'b0;
         end
         else
         begin
            counter_preset_reg <= wr && (idx == ir_remote_pkg::COUNTER_CONTROL_IDX)
               && block_enable_reg
               && bit_written(wdata, PSTRB[1:0], ir_remote_pkg::COUNTER_PRESET_BIT);
            if (wr && (idx == ir_remote_pkg::COUNTER_CONTROL_IDX) && PSTRB[1]
                && block_enable_reg)
            begin
               counter_run_reg <= wdata[ir_remote_pkg::COUNTER_RUN_BIT];
            end
            else if (cycle_end && one_shot_select_reg)
            begin
               counter_run_reg <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // data counter and flags
   // ----------------------------------------------------------------
   // counts 0..cycle length, wraps in repeat mode, parks at zero in one-shot
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         data_counter_reg <= '0;
      else if (CLK_EN)
      begin
         if (soft_reset_reg || counter_preset_reg)
            data_counter_reg <= '0;
         else if (cycle_end)
            data_counter_reg <= '0;
         else if (count_step)
            data_counter_reg <= data_counter_reg + 1'b1;
      end
   end

   // sticky flags: a compare event wins over a same-cycle write-one clear
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         flags_reg <= '0;
      end
      else if (CLK_EN)
      begin
         if (soft_reset_reg)
            flags_reg <= '0;
         else
            flags_reg <= (flags_reg
               & ~((wr && (idx == ir_remote_pkg::STATUS_FLAGS_IDX) && PSTRB[0])
                   ? wdata[1:0] : 2'h0))
               | {cycle_end, active_end};
      end
   end

   // registered pin and interrupt
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         IR_OUTPUT_PIN <= 1'b0;
         IRQ <= 1'b0;
      end
      else if (CLK_EN)
      begin
         IR_OUTPUT_PIN <= out_active ^ output_invert_reg;
         IRQ <= |(flags_reg & mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_soft_reset_clears;
      (CLK_EN && soft_reset_reg) |=> (data_counter_reg == '0) && (flags_reg == '0);
   endproperty
   a_soft_reset_clears: assert property (p_soft_reset_clears)
      else $error("soft reset left counter or flags set");
   property p_soft_reset_self_clear;
      (CLK_EN && soft_reset_reg) |=> !soft_reset_reg && !counter_run_reg;
   endproperty
   a_soft_reset_self_clear: assert property (p_soft_reset_self_clear)
      else $error("soft reset did not clear itself");
   property p_pin_level;
      CLK_EN |=> IR_OUTPUT_PIN == ($past(out_active) ^ $past(output_invert_reg));
   endproperty
   a_pin_level: assert property (p_pin_level)
      else $error("output pin level wrong for invert setting");
   property p_zero_is_active;
      (CLK_EN && counter_run_reg && data_counter_reg == '0)
         |=> IR_OUTPUT_PIN != $past(output_invert_reg);
   endproperty
   a_zero_is_active: assert property (p_zero_is_active)
      else $error("output not active at counter zero");
   property p_past_active_inactive;
      (CLK_EN && data_counter_reg > active_length_reg)
         |=> IR_OUTPUT_PIN == $past(output_invert_reg);
   endproperty
   a_past_active_inactive: assert property (p_past_active_inactive)
      else $error("output still active past active length");
   property p_repeat_wrap;
      (CLK_EN && cycle_end && !one_shot_select_reg && !wr)
         |=> data_counter_reg == '0 && counter_run_reg && flags_reg[1];
   endproperty
   a_repeat_wrap: assert property (p_repeat_wrap)
      else $error("repeat cycle did not wrap to zero");
   property p_one_shot_stop;
      (CLK_EN && cycle_end && one_shot_select_reg && !wr)
         |=> !counter_run_reg ##1 (!CLK_EN || data_counter_reg == '0);
   endproperty
   a_one_shot_stop: assert property (p_one_shot_stop)
      else $error("one-shot run did not stop");
   property p_disabled_frozen;
      (CLK_EN && !block_enable_reg && !soft_reset_reg && !counter_preset_reg)
         |=> $stable(data_counter_reg);
   endproperty
   a_disabled_frozen: assert property (p_disabled_frozen)
      else $error("counter moved while block disabled");
   property p_irq_follows;
      CLK_EN |=> IRQ == |($past(flags_reg) & $past(mask_reg));
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("interrupt output does not match masked flags");

   c_one_shot_end: cover property (cycle_end && one_shot_select_reg);
   c_repeat_wrap: cover property (cycle_end && !one_shot_select_reg);
   c_irq_raised: cover property (!IRQ ##1 IRQ);

endmodule // ir_remote_data_signal_generator
`default_nettype wire

/* File: testbench/ir_emitter_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// emitter: measures pulse and period widths
// ----------------------------------------
module ir_emitter_model
(
   input  wire logic        clk,
   input  wire logic        pin,
   output logic [15:0]      hi_w,
   output logic [15:0]      per_w
);
   logic        pin_q = 1'b0;
   logic [15:0] hi_cnt = 16'h0000;
   logic [15:0] per_cnt = 16'h0000;
   initial hi_w = 16'h0000;
   initial per_w = 16'h0000;
   // emitter lights while the pin is high, whatever the invert setting; widths counted in core cycles
   always @(posedge clk)
   begin
      pin_q <= pin;
      hi_cnt <= pin ? hi_cnt + 16'h0001 : 16'h0000;
      per_cnt <= (pin && !pin_q) ? 16'h0001 : per_cnt + 16'h0001;
      if (!pin && pin_q)
         hi_w <= hi_cnt;
      if (pin && !pin_q)
         per_w <= per_cnt;
   end
endmodule // ir_emitter_model
`default_nettype wire

/* File: testbench/ir_remote_data_signal_generator_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module ir_remote_data_signal_generator_tb;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        fosc = 1'b0, sosc = 1'b0, er, pin, irq, pready, pslverr;
   logic [15:0] paddr = 16'h0000, rd, hi_w, per_w;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic [3:0]  pstrb = 4'h0, sc = 4'h0;
   logic [1:0]  fc = 2'h0;
   int          n_errors = 0, num_checks = 0;
   ir_remote_data_signal_generator dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FAST_INTERNAL_OSCILLATOR(fosc), .LOW_SPEED_OSCILLATOR(sosc),
      .IR_OUTPUT_PIN(pin), .IRQ(irq));
   ir_emitter_model emitter (.clk(clk), .pin(pin), .hi_w(hi_w), .per_w(per_w));
   // ----------------------------------------
   // clocks: core 100 ns, fast source 4 cycles, slow source 12 cycles
   // ----------------------------------------
   initial forever #50 clk = ~clk;
   always @(posedge clk)
   begin
      fc <= fc + 2'h1;
      fosc <= fc[1];
      sc <= (sc == 4'hB) ? 4'h0 : sc + 4'h1;
      sosc <= (sc < 4'h6);
   end
   // ----------------------------------------
   // bus, compare and closing tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                      input logic [3:0] st);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= {idx[13:0], 2'b00};
      pwdata <= {16'h0000, d}; pstrb <= st;
      @(posedge clk);
      penable <= 1'b1;
      // hold the request until ready is seen at an edge
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
      rd = prdata[15:0]; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (k >= 50) n_errors++;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin n_errors++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // clocking changed only while disabled, then soft reset and run
   task automatic run_with(input logic [15:0] clkcfg, input int cyc);
      apb(1, 16'h0722, 16'h0000, 4'h3);
      apb(1, 16'h0720, clkcfg, 4'h3);
      apb(1, 16'h0722, 16'h0003, 4'h3);
      apb(1, 16'h0722, 16'h0101, 4'h3);
      repeat (cyc) @(posedge clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_and_map();
      for (int i = 0; i < 7; i++) begin apb(0, 16'h0720 + 16'(2 * i), 0, 0); chk(rd, 0); end
      apb(0, 16'h0730, 0, 0); chk({15'h0, er}, 16'h0001);
      apb(1, 16'h0722, 16'h0100, 4'h3);  // run while disabled
      apb(0, 16'h0722, 0, 0); chk(rd, 16'h0000);
   endtask
   task automatic t_repeat();
      apb(1, 16'h0722, 16'h0001, 4'h3);
      apb(1, 16'h0726, 16'h0001, 4'h1); apb(1, 16'h0726, 16'h0000, 4'h2);
      apb(1, 16'h0728, 16'h0003, 4'h1); apb(1, 16'h0728, 16'h0000, 4'h2);
      run_with(16'h0000, 80);
      chk(hi_w, 16'h0008);
      chk(per_w, 16'h0010);
      apb(0, 16'h072A, 0, 0); chk(rd & 16'h0400, 16'h0400);
      run_with(16'h0010, 140); chk(per_w, 16'h0020);
      run_with(16'h0091, 200); chk(per_w, 16'h0030);
      // preset while running: counter restarts, preset bit gone, run kept
      apb(1, 16'h0722, 16'h0301, 4'h3);
      apb(0, 16'h0724, 0, 0); chk(rd, 16'h0000);
      apb(0, 16'h0722, 0, 0); chk(rd, 16'h0101);
   endtask
   task automatic t_one_shot_irq();
      apb(1, 16'h072C, 16'h0002, 4'h3);
      apb(1, 16'h0722, 16'h0000, 4'h3);
      apb(1, 16'h0720, 16'h0000, 4'h3);
      apb(1, 16'h0722, 16'h0003, 4'h3);
      apb(1, 16'h0722, 16'h0105, 4'h3);
      repeat (40) @(posedge clk);
      apb(0, 16'h0722, 0, 0); chk(rd, 16'h0005);
      apb(0, 16'h072A, 0, 0); chk(rd, 16'h0003);
      chk({15'h0, irq}, 16'h0001);
      apb(1, 16'h072A, 16'h0003, 4'h3); repeat (2) @(posedge clk);
      apb(0, 16'h072A, 0, 0); chk(rd, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      apb(1, 16'h0722, 16'h0007, 4'h3);
      apb(0, 16'h0724, 0, 0); chk(rd, 16'h0000);
      apb(0, 16'h0722, 0, 0); chk(rd, 16'h0005);
      apb(1, 16'h0722, 16'h0019, 4'h3); repeat (3) @(posedge clk);
      chk({15'h0, pin}, 16'h0001);
      apb(0, 16'h0722, 0, 0); chk(rd, 16'h0019);
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_and_map();
      t_repeat();
      t_one_shot_irq();
      final_report();
   end
   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end
endmodule // ir_remote_data_signal_generator_tb
`default_nettype wire
